// ===== shared/wmc_defines.vh
`ifndef WMC_DEFINES_VH
`define WMC_DEFINES_VH

// ==========================================
// Special-function addresses
`define WMC_ADDR_PTR0_LO     8'h82
`define WMC_ADDR_PTR0_HI     8'h83
`define WMC_ADDR_PTR1_LO     8'h84
`define WMC_ADDR_PTR1_HI     8'h85
`define WMC_ADDR_PWR_CTRL    8'h87
`define WMC_ADDR_WD_MEM_CTRL 8'h96

// ==========================================
// Control register fields and reset values
`define WMC_BIT_PS_LO       5
`define WMC_BIT_PS_HI       7
`define WMC_BIT_NVM_WE      4
`define WMC_BIT_NVM_EN      3
`define WMC_BIT_BANK_SEL    2
`define WMC_BIT_RESTART     1
`define WMC_BIT_WD_EN       0
`define WMC_BIT_PWR_LOSS    4
`define WMC_CTRL_RESET      8'h02
`define WMC_PTR_RESET       16'h0000

// ==========================================
// Watchdog timing
`define WMC_WD_BASE_MS      16
`define WMC_CLK_MHZ         200
`define WMC_WD_BASE_CYC     (`WMC_WD_BASE_MS * 1000 * `WMC_CLK_MHZ)

`endif

// ===== src/wmc_pointer_bank.v
`timescale 1ns/1ps
`include "wmc_defines.vh"

// One 16-bit data pointer bank with byte-wide writes
module wmc_pointer_bank
#(
    parameter WIDTH = 16
)
(
    input  wire             mclk,
    input  wire             rst_n,
    input  wire             clkEn,
    input  wire             wrLo,
    input  wire             wrHi,
    input  wire [7:0]       wrData,
    input  wire             wrWord,
    input  wire [WIDTH-1:0] wordData,
    output reg  [WIDTH-1:0] ptrValue
);

    // ==========================================
    // Byte writes from the bus, word writes from the core
    always @(posedge mclk)
    begin
        if (!rst_n)
            ptrValue <= `WMC_PTR_RESET;
        else if (clkEn)
        begin
            if (wrWord)
                ptrValue <= wordData;
            else
            begin
                if (wrLo)
                    ptrValue[7:0] <= wrData;
                if (wrHi)
                    ptrValue[WIDTH-1:8] <= wrData;
            end
        end
    end

endmodule

// ===== src/wmc_control_bank.v
`timescale 1ns/1ps
`include "wmc_defines.vh"

module wmc_control_bank
#(
    parameter WD_BASE_CYCLES = `WMC_WD_BASE_CYC,
    parameter CNT_WIDTH      = 32
)
(
    input  wire        mclk,
    input  wire        rst_n,
    input  wire        powerOnRst_n,
    input  wire        clkEn,
    input  wire [7:0]  sfrAddr,
    input  wire        sfrWr,
    input  wire        sfrRd,
    input  wire [7:0]  sfrWrData,
    output reg  [7:0]  sfrRdData,
    output wire        sfrHit,
    input  wire        ptrWordWr,
    input  wire [15:0] ptrWordData,
    output wire [15:0] dataPointer,
    output wire        nvmSelect,
    output wire        nvmWriteEnable,
    input  wire        nvmBusy,
    input  wire        powerDown,
    output reg         wdResetPulse,
    output wire        wdRestartPulse
);

    // ==========================================
    // Control register state
    reg  [7:0]           ctrl_reg;
    reg  [7:0]           ctrl_next;
    reg                  restart_reg;
    reg                  powerLoss_reg;
    reg                  busySync1_reg;
    reg                  busySync2_reg;
    reg  [CNT_WIDTH-1:0] wdCount_reg;
    reg                  wdEnPrev_reg;

    wire [15:0] firstPointerBank;
    wire [15:0] secondPointerBank;
    wire        wrCtrl = clkEn & sfrWr & (sfrAddr == `WMC_ADDR_WD_MEM_CTRL);
    wire        wrPwrCtrl = clkEn & sfrWr & (sfrAddr == `WMC_ADDR_PWR_CTRL);
    wire        bankSel = ctrl_reg[`WMC_BIT_BANK_SEL];
    wire        wdEnable = ctrl_reg[`WMC_BIT_WD_EN];
    wire [2:0]  periodSel = ctrl_reg[`WMC_BIT_PS_HI:`WMC_BIT_PS_LO];

    // Address decode for this bank's registers
    assign sfrHit = (sfrAddr == `WMC_ADDR_WD_MEM_CTRL) | (sfrAddr == `WMC_ADDR_PWR_CTRL) |
                    (sfrAddr == `WMC_ADDR_PTR0_LO) | (sfrAddr == `WMC_ADDR_PTR0_HI) |
                    (sfrAddr == `WMC_ADDR_PTR1_LO) | (sfrAddr == `WMC_ADDR_PTR1_HI);

    // ==========================================
    // Pointer banks
    // A core word write beats byte writes landing in the same cycle
    wmc_pointer_bank #(.WIDTH(16)) firstBank
    (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .wrLo     (sfrWr & (sfrAddr == `WMC_ADDR_PTR0_LO)),
        .wrHi     (sfrWr & (sfrAddr == `WMC_ADDR_PTR0_HI)),
        .wrData   (sfrWrData),
        .wrWord   (ptrWordWr & ~bankSel),
        .wordData (ptrWordData),
        .ptrValue (firstPointerBank)
    );

    wmc_pointer_bank #(.WIDTH(16)) secondBank
    (
        .mclk     (mclk),
        .rst_n    (rst_n),
        .clkEn    (clkEn),
        .wrLo     (sfrWr & (sfrAddr == `WMC_ADDR_PTR1_LO)),
        .wrHi     (sfrWr & (sfrAddr == `WMC_ADDR_PTR1_HI)),
        .wrData   (sfrWrData),
        .wrWord   (ptrWordWr & bankSel),
        .wordData (ptrWordData),
        .ptrValue (secondPointerBank)
    );

    // Core's pointer view follows the select bit; software must set it first
    assign dataPointer = bankSel ? secondPointerBank : firstPointerBank;

    // ==========================================
    // Memory steering outputs
    assign nvmSelect      = ctrl_reg[`WMC_BIT_NVM_EN];
    assign nvmWriteEnable = ctrl_reg[`WMC_BIT_NVM_WE];

    // ==========================================
    // Control register next value; writes never store the restart bit
    always @*
    begin
        ctrl_next = ctrl_reg;
        if (wrCtrl)
            ctrl_next = sfrWrData & ~(8'h01 << `WMC_BIT_RESTART);
        // Power-down beats a same-cycle enable write
        if (powerDown)
            ctrl_next[`WMC_BIT_WD_EN] = 1'b0;
    end

    // Reset loads the documented pattern
    always @(posedge mclk)
    begin
        if (!rst_n || !powerOnRst_n)
            ctrl_reg <= `WMC_CTRL_RESET;
        else if (clkEn)
            ctrl_reg <= ctrl_next;
    end

    // ==========================================
    // Restart pulse: one cycle, then gone
    // Registered, so the counter clear lands one cycle after the write
    always @(posedge mclk)
    begin
        if (!rst_n)
            restart_reg <= 1'b0;
        else if (clkEn)
            restart_reg <= wrCtrl & sfrWrData[`WMC_BIT_RESTART];
    end

    assign wdRestartPulse = restart_reg;

    // ==========================================
    // Power-loss flag: power-on or a software write of one sets it, system reset ignored
    // Software writes are frozen by the clock enable like all other state
    always @(posedge mclk)
    begin
        if (!powerOnRst_n)
            powerLoss_reg <= 1'b1;
        else if (wrPwrCtrl)
            powerLoss_reg <= sfrWrData[`WMC_BIT_PWR_LOSS];
    end

    // ==========================================
    // Busy comes from the memory's own timer, so synchronise it
    // Only the second stage is read; the first may still be settling
    always @(posedge mclk)
    begin
        if (!rst_n)
        begin
            busySync1_reg <= 1'b0;
            busySync2_reg <= 1'b0;
        end
        else if (clkEn)
        begin
            busySync1_reg <= nvmBusy;
            busySync2_reg <= busySync1_reg;
        end
    end

    // ==========================================
    // Watchdog counter; clears on enable edge and restart
    // Base period doubles per prescaler step; CNT_WIDTH of at most 32 keeps
    // the select inside the integer base and still holds the longest period
    wire [CNT_WIDTH-1:0] wdLimit = WD_BASE_CYCLES[CNT_WIDTH-1:0] << periodSel;

    always @(posedge mclk)
    begin
        if (!rst_n || !powerOnRst_n)
        begin
            wdCount_reg  <= {CNT_WIDTH{1'b0}};
            wdEnPrev_reg <= 1'b0;
            wdResetPulse <= 1'b0;
        end
        else if (clkEn)
        begin
            wdEnPrev_reg <= wdEnable;
            wdResetPulse <= 1'b0;
            if (!wdEnable || !wdEnPrev_reg || restart_reg)
                wdCount_reg <= {CNT_WIDTH{1'b0}};
            else if (wdCount_reg >= wdLimit - 1'b1)
            begin
                wdCount_reg  <= {CNT_WIDTH{1'b0}};
                wdResetPulse <= 1'b1;
            end
            else
                wdCount_reg <= wdCount_reg + 1'b1;
        end
    end

    // ==========================================
    // Read mux; restart position shows ready, the inverse of busy
    wire nvmReady = ~busySync2_reg;

    // Stored restart bit is never returned
    always @(posedge mclk)
    begin
        if (!rst_n)
            sfrRdData <= 8'h00;
        else if (clkEn && sfrRd)
        begin
            case (sfrAddr)
                `WMC_ADDR_WD_MEM_CTRL: sfrRdData <= {ctrl_reg[7:2], nvmReady, ctrl_reg[0]};
                `WMC_ADDR_PWR_CTRL:    sfrRdData <= {3'h0, powerLoss_reg, 4'h0};
                `WMC_ADDR_PTR0_LO:     sfrRdData <= firstPointerBank[7:0];
                `WMC_ADDR_PTR0_HI:     sfrRdData <= firstPointerBank[15:8];
                `WMC_ADDR_PTR1_LO:     sfrRdData <= secondPointerBank[7:0];
                `WMC_ADDR_PTR1_HI:     sfrRdData <= secondPointerBank[15:8];
                default:         sfrRdData <= 8'h00;
            endcase
        end
    end

endmodule

// ===== sim/wmc_nvm_model.sv
`timescale 1ns/1ps
// ====
// EEPROM programming stand-in
module wmc_nvm_model
#(
    parameter BUSY_CYC = 20
)
(
    input  wire logic mclk,
    input  wire logic startWr,
    input  wire logic writeEnable,
    output logic      nvmBusy
);
    int cnt = 0;
    // Write without the enable bit is ignored, as real parts do
    always @(posedge mclk)
    begin
        if (startWr && writeEnable)
            cnt <= BUSY_CYC;
        else if (cnt != 0)
            cnt <= cnt - 1;
    end
    assign nvmBusy = (cnt != 0);
endmodule

// ===== sim/wmc_control_bank_assertions.sv
`timescale 1ns/1ps
// ====
// Port checker
module wmc_chk
#(
    parameter WD_BASE_CYCLES = 8,
    parameter CNT_WIDTH      = 32
)
(
    input logic        mclk,
    input logic        rst_n,
    input logic        powerOnRst_n,
    input logic        clkEn,
    input logic [7:0]  sfrAddr,
    input logic        sfrWr,
    input logic        sfrRd,
    input logic [7:0]  sfrWrData,
    input logic [7:0]  sfrRdData,
    input logic        sfrHit,
    input logic        ptrWordWr,
    input logic [15:0] ptrWordData,
    input logic [15:0] dataPointer,
    input logic        nvmSelect,
    input logic        nvmWriteEnable,
    input logic        nvmBusy,
    input logic        powerDown,
    input logic        wdResetPulse,
    input logic        wdRestartPulse
);
    default clocking @(posedge mclk); endclocking
    default disable iff (!rst_n || !powerOnRst_n);
    wire wrCtl = sfrWr && clkEn && sfrAddr == 8'h96;
    // ====
    // Assertions
    a_restart_fire: assert property (wrCtl && sfrWrData[1] |=> wdRestartPulse)
        else $error("restart pulse missing");
    a_restart_cause: assert property (wdRestartPulse |-> $past(wrCtl && sfrWrData[1]))
        else $error("restart pulse without write");
    a_sel_follow: assert property (wrCtl |=> nvmSelect == $past(sfrWrData[3]))
        else $error("access select wrong");
    a_we_follow: assert property (wrCtl |=> nvmWriteEnable == $past(sfrWrData[4]))
        else $error("write enable wrong");
    a_ptr_load: assert property (ptrWordWr && clkEn && !wrCtl |=> dataPointer == $past(ptrWordData))
        else $error("pointer load wrong");
    a_reset_value: assert property (disable iff (1'b0) !rst_n |=> !nvmSelect && !nvmWriteEnable
        && dataPointer == 16'h0000 && !wdRestartPulse)
        else $error("reset value wrong");
    a_hit_decode: assert property (sfrHit == (sfrAddr inside {[8'h82:8'h85], 8'h87, 8'h96}))
        else $error("address decode wrong");
    a_restart_quiet: assert property (wdRestartPulse |=> !wdResetPulse [*5])
        else $error("expiry too soon after restart");
    a_expiry_single: assert property (wdResetPulse && clkEn |=> !wdResetPulse)
        else $error("expiry pulse too long");
    a_unmapped_zero: assert property (sfrRd && clkEn && !sfrHit |=> sfrRdData == 8'h00)
        else $error("unmapped read not zero");
endmodule

bind wmc_control_bank wmc_chk #(.WD_BASE_CYCLES(WD_BASE_CYCLES), .CNT_WIDTH(CNT_WIDTH)) chk
(
    .mclk           (mclk),
    .rst_n          (rst_n),
    .powerOnRst_n   (powerOnRst_n),
    .clkEn          (clkEn),
    .sfrAddr        (sfrAddr),
    .sfrWr          (sfrWr),
    .sfrRd          (sfrRd),
    .sfrWrData      (sfrWrData),
    .sfrRdData      (sfrRdData),
    .sfrHit         (sfrHit),
    .ptrWordWr      (ptrWordWr),
    .ptrWordData    (ptrWordData),
    .dataPointer    (dataPointer),
    .nvmSelect      (nvmSelect),
    .nvmWriteEnable (nvmWriteEnable),
    .nvmBusy        (nvmBusy),
    .powerDown      (powerDown),
    .wdResetPulse   (wdResetPulse),
    .wdRestartPulse (wdRestartPulse)
);

// ===== sim/tb.sv
`timescale 1ns/1ps
// ====
// Bench top
module tb;
    logic        mclk = 0, rst_n = 0, powerOnRst_n = 0, sfrWr = 0, sfrRd = 0;
    logic        ptrWordWr = 0, powerDown = 0, nvmGo = 0, clkEn = 1, nvmBusy;
    logic [7:0]  sfrAddr = 0, sfrWrData = 0, sfrRdData, v;
    logic [15:0] ptrWordData = 0, dataPointer;
    logic        nvmSelect, nvmWriteEnable, wdResetPulse, wdRestartPulse;
    int          numErrors = 0, nChecks = 0, nPulse = 0, g, n;
    logic [23:0] rows[8] = '{24'h825a5a, 24'h83a5a5, 24'h843c3c, 24'h85c3c3,
                             24'h96fcfe, 24'h871010, 24'h870000, 24'h90ff00};
    wmc_control_bank #(.WD_BASE_CYCLES(8)) dut (.mclk(mclk), .rst_n(rst_n),
        .powerOnRst_n(powerOnRst_n), .clkEn(clkEn), .sfrAddr(sfrAddr), .sfrWr(sfrWr),
        .sfrRd(sfrRd), .sfrWrData(sfrWrData), .sfrRdData(sfrRdData), .sfrHit(),
        .ptrWordWr(ptrWordWr), .ptrWordData(ptrWordData), .dataPointer(dataPointer),
        .nvmSelect(nvmSelect), .nvmWriteEnable(nvmWriteEnable), .nvmBusy(nvmBusy),
        .powerDown(powerDown), .wdResetPulse(wdResetPulse), .wdRestartPulse(wdRestartPulse));
    wmc_nvm_model nvm (.mclk(mclk), .startWr(nvmGo), .writeEnable(nvmWriteEnable), .nvmBusy(nvmBusy));
    // 200 MHz clock and expiry counter
    initial forever #2.5 mclk = ~mclk;
    always @(posedge mclk) nPulse <= nPulse + wdResetPulse;
    // ====
    // Bus tasks
    task chk(input logic [15:0] s, input logic [15:0] e);
        nChecks++;
        if (s !== e)
        begin
            numErrors++;
            $display("wrong value at %0t: got %h want %h", $time, s, e);
        end
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        {sfrAddr, sfrWrData, sfrWr} <= {a, d, 1'b1};
        @(posedge mclk);
        sfrWr <= 0;
        #1;
    endtask
    task rd(input logic [7:0] a);
        @(posedge mclk);
        {sfrAddr, sfrRd} <= {a, 1'b1};
        @(posedge mclk);
        sfrRd <= 0;
        #1 v = sfrRdData;
    endtask
    // Pulse-to-pulse spacing of watchdog expiries, less one
    task gap;
        repeat (2)
        begin
            g = 0;
            @(posedge mclk);
            #1;
            while (wdResetPulse !== 1'b1 && g < 3000)
            begin
                @(posedge mclk);
                #1 g++;
            end
        end
    endtask
    task print_verdict;
        $display("checks %0d errors %0d", nChecks, numErrors);
        if (numErrors == 0 && nChecks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask
    // Hang guard, far beyond the few thousand cycles expected
    initial
    begin
        #60000 numErrors++;
        print_verdict;
    end
    // ====
    // Tests
    initial
    begin
        repeat (10) @(posedge mclk);
        {rst_n, powerOnRst_n} <= 2'b11;
        rd(8'h96); chk(v, 8'h02);
        rd(8'h87); chk(v, 8'h10);
        $display("reset test done");
        foreach (rows[i])
        begin
            wr(rows[i][23:16], rows[i][15:8]);
            rd(rows[i][23:16]); chk(v, rows[i][7:0]);
        end
        $display("row test done");
        wr(8'h96, 8'h04); chk(dataPointer, 16'hc33c);
        wr(8'h96, 8'h00); chk(dataPointer, 16'ha55a);
        @(posedge mclk) {ptrWordWr, ptrWordData} <= {1'b1, 16'hbeef};
        @(posedge mclk) ptrWordWr <= 0;
        #1 chk(dataPointer, 16'hbeef);
        @(posedge mclk) rst_n <= 0;
        @(posedge mclk) rst_n <= 1;
        rd(8'h87); chk(v, 8'h00);
        rd(8'h82); chk(v, 8'h00);
        // Clock enable low: a pointer write must not land
        @(posedge mclk) clkEn <= 0;
        wr(8'h82, 8'h77);
        @(posedge mclk) clkEn <= 1;
        rd(8'h82); chk(v, 8'h00);
        $display("pointer and flag test done");
        for (int c = 0; c < 3; c++)
        begin
            wr(8'h96, {c[2:0], 5'h01});
            gap; chk(g + 1, 16'd8 << c);
        end
        wr(8'h96, 8'hf1); gap; chk(g + 1, 16'd1024);
        wr(8'h96, 8'h01); wr(8'h96, 8'h03); n = nPulse;
        repeat (15) wr(8'h96, 8'h03); chk(nPulse, n);
        wr(8'h96, 8'h00); n = nPulse;
        repeat (40) @(posedge mclk); chk(nPulse, n);
        wr(8'h96, 8'h01);
        @(posedge mclk) powerDown <= 1;
        @(posedge mclk) powerDown <= 0;
        rd(8'h96); chk(v, 8'h02);
        $display("watchdog test done");
        wr(8'h96, 8'h18); chk({nvmSelect, nvmWriteEnable}, 2'b11);
        @(posedge mclk) nvmGo <= 1;
        @(posedge mclk) nvmGo <= 0;
        repeat (5) @(posedge mclk);
        rd(8'h96); chk(v, 8'h18);
        repeat (30) @(posedge mclk);
        rd(8'h96); chk(v, 8'h1a);
        $display("eeprom test done");
        print_verdict;
    end
endmodule
